// ### inc/dma_defs.vh
// register map, field positions and reset values of the four-channel copy engine
`ifndef DMA_DEFS_VH
`define DMA_DEFS_VH
`define DMA_CHANNELS       4
`define DMA_CH_STRIDE      13'h1000
`define DMA_OFF_CTRL       12'h000
`define DMA_OFF_PTYPE      12'h004
`define DMA_OFF_PLEN_LO    12'h008
`define DMA_OFF_PLEN_HI    12'h00c
`define DMA_OFF_PDST_LO    12'h010
`define DMA_OFF_PDST_HI    12'h014
`define DMA_OFF_PSRC_LO    12'h018
`define DMA_OFF_PSRC_HI    12'h01c
`define DMA_OFF_ATYPE      12'h104
`define DMA_OFF_ALEN_LO    12'h108
`define DMA_OFF_ALEN_HI    12'h10c
`define DMA_OFF_ADST_LO    12'h110
`define DMA_OFF_ADST_HI    12'h114
`define DMA_OFF_ASRC_LO    12'h118
`define DMA_OFF_ASRC_HI    12'h11c
`define DMA_CTRL_RESERVE   0
`define DMA_CTRL_START     1
`define DMA_CTRL_DONE_IE   14
`define DMA_CTRL_ERR_IE    15
`define DMA_CTRL_DONE      30
`define DMA_CTRL_ERR       31
`define DMA_TYPE_REPEAT    2
`define DMA_TYPE_ORDER     3
`define DMA_TYPE_WSIZE_LSB 24
`define DMA_TYPE_RSIZE_LSB 28
`define DMA_MAX_LOG2SIZE   4'h6
`define DMA_TYPE_MASK      32'hff00_000c
`define DMA_CTRL_RESET     32'h0000_0000
`endif

// ### rtl/dma_engine.v
// four-channel memory-to-memory copy engine with register slave and data master ports
// Summary of operation
// [R1] four channels, each with own registers, all able to run concurrently
// [R2] registers via slave port; data moves via separate master port
// [R3] each channel drives a completion interrupt and an error interrupt
// [R4] channel block at base plus index times 0x1000, same offsets repeat
// [R5] pending length is 64-bit read-write, bytes for the next transfer
// [R6] active length is read-only 64-bit, bytes still to move
// [R7] control word shows status: reserve, start, interrupt enables, completion
// [R8] bit 0 reserves channel; setting it clears pending type, length, addresses
// [R9] reserve bit clears only while start bit is low
// [R10] setting bit 1 copies pending set to active set and starts moving
// [R11] bit 14 enables completion interrupt when a transfer finishes
// [R12] bit 15 enables error interrupt on bus error; reserved bits reset zero
// [R13] bit 30 records completion, bit 31 records error since reservation
// [R14] transfer type holds log2 sizes, capped at 64 bytes, read back legal
// [R15] repeat reloads active set on completion and keeps start bit high
// [R16] each transaction advances addresses, decrements length; start clears at zero
// [R17] software reserves, programs pending set, then starts; no racing rewrites
`timescale 1ns/1ps
`include "dma_defs.vh"
module dma_engine (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        s_valid,
  input  wire        s_write,
  input  wire [13:0] s_addr,
  input  wire [31:0] s_wdata,
  output reg         s_ready,
  output reg  [31:0] s_rdata,
  output reg         s_err,
  output reg         m_valid,
  output reg  [63:0] m_src_addr,
  output reg  [63:0] m_dst_addr,
  output reg  [6:0]  m_size,
  output reg  [1:0]  m_channel,
  input  wire        m_ready,
  input  wire        m_done,
  input  wire        m_bus_err,
  output reg  [3:0]  done_irq,
  output reg  [3:0]  fault_irq
);

  // clamp a requested log2 size to the largest legal transaction
  function [3:0] legal_size;
    input [3:0] req;
    begin
      legal_size = (req > `DMA_MAX_LOG2SIZE) ? `DMA_MAX_LOG2SIZE : req;
    end
  endfunction

  // legalise a whole transfer-type word
  function [31:0] legal_type;
    input [31:0] w;
    begin
      legal_type = w & `DMA_TYPE_MASK;
      legal_type[`DMA_TYPE_WSIZE_LSB+3:`DMA_TYPE_WSIZE_LSB] =
        legal_size(w[`DMA_TYPE_WSIZE_LSB+3:`DMA_TYPE_WSIZE_LSB]);
      legal_type[`DMA_TYPE_RSIZE_LSB+3:`DMA_TYPE_RSIZE_LSB] =
        legal_size(w[`DMA_TYPE_RSIZE_LSB+3:`DMA_TYPE_RSIZE_LSB]);
    end
  endfunction

  // bytes in one transaction: smaller of the two sizes and of what remains
  function [63:0] step_bytes;
    input [31:0] t;
    input [63:0] rem;
    reg   [3:0]  ws;
    reg   [3:0]  rs;
    reg   [63:0] sz;
    begin
      ws = t[`DMA_TYPE_WSIZE_LSB+3:`DMA_TYPE_WSIZE_LSB];
      rs = t[`DMA_TYPE_RSIZE_LSB+3:`DMA_TYPE_RSIZE_LSB];
      sz = 64'h0000_0000_0000_0001 << ((ws < rs) ? ws : rs);
      step_bytes = (rem < sz) ? rem : sz;
    end
  endfunction

  // pending set is written by software; the active set is copied from it on start
  reg [31:0] ctrl_r  [0:3];
  reg [31:0] ptype_r [0:3];
  reg [63:0] plen_r  [0:3];
  reg [63:0] pdst_r  [0:3];
  reg [63:0] psrc_r  [0:3];
  reg [31:0] atype_r [0:3];
  reg [63:0] alen_r  [0:3];
  reg [63:0] adst_r  [0:3];
  reg [63:0] asrc_r  [0:3];
  reg [3:0]  busy_r;
  reg [1:0]  rr_r;
  reg [1:0]  owner_r;
  reg        inflight_r;
  reg [63:0] step_r;

  wire [1:0]  sel_ch  = s_addr[13:12];                            // [R4]
  wire [11:0] sel_off = s_addr[11:0];
  wire        wr_go   = s_valid && s_write && !s_ready;
  wire        rd_go   = s_valid && !s_write && !s_ready;
  // writes into the read-only active set are dropped without an error
  wire        wr_ro   = wr_go && sel_off[8];

  // a channel wants the master port while started, length left and idle
  wire [3:0] want;
  genvar g;
  generate
    for (g = 0; g < `DMA_CHANNELS; g = g + 1) begin : g_want
      assign want[g] = ctrl_r[g][`DMA_CTRL_START] && !busy_r[g]
                       && (alen_r[g] != 64'h0000_0000_0000_0000);
    end
  endgenerate

  // round-robin pick for the shared master port
  // the search starts after the last winner so no waiting channel starves
  reg [1:0] pick;
  reg       pick_ok;
  reg [1:0] cand;
  integer k;
  always @* begin
    pick = 2'h0;
    pick_ok = 1'b0;
    cand = 2'h0;
    for (k = 3; k >= 0; k = k - 1) begin
      cand = rr_r + k[1:0] + 2'h1;
      if (want[cand]) begin
        pick = cand;
        pick_ok = 1'b1;
      end
    end
  end

  // bytes the picked channel would move in its next transaction
  wire [63:0] pick_step = step_bytes(atype_r[pick], alen_r[pick]);

  // register read mux
  reg [31:0] rd_val;
  reg        rd_bad;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_bad = 1'b0;
    if (sel_off == `DMA_OFF_CTRL) begin
      rd_val = ctrl_r[sel_ch];                                     // [R7]
    end else if (sel_off == `DMA_OFF_PTYPE) begin
      rd_val = ptype_r[sel_ch];                                    // [R14]
    end else if (sel_off == `DMA_OFF_PLEN_LO) begin
      rd_val = plen_r[sel_ch][31:0];                               // [R5]
    end else if (sel_off == `DMA_OFF_PLEN_HI) begin
      rd_val = plen_r[sel_ch][63:32];
    end else if (sel_off == `DMA_OFF_PDST_LO) begin
      rd_val = pdst_r[sel_ch][31:0];
    end else if (sel_off == `DMA_OFF_PDST_HI) begin
      rd_val = pdst_r[sel_ch][63:32];
    end else if (sel_off == `DMA_OFF_PSRC_LO) begin
      rd_val = psrc_r[sel_ch][31:0];
    end else if (sel_off == `DMA_OFF_PSRC_HI) begin
      rd_val = psrc_r[sel_ch][63:32];
    end else if (sel_off == `DMA_OFF_ATYPE) begin
      rd_val = atype_r[sel_ch];
    end else if (sel_off == `DMA_OFF_ALEN_LO) begin
      rd_val = alen_r[sel_ch][31:0];                               // [R6]
    end else if (sel_off == `DMA_OFF_ALEN_HI) begin
      rd_val = alen_r[sel_ch][63:32];
    end else if (sel_off == `DMA_OFF_ADST_LO) begin
      rd_val = adst_r[sel_ch][31:0];
    end else if (sel_off == `DMA_OFF_ADST_HI) begin
      rd_val = adst_r[sel_ch][63:32];
    end else if (sel_off == `DMA_OFF_ASRC_LO) begin
      rd_val = asrc_r[sel_ch][31:0];
    end else if (sel_off == `DMA_OFF_ASRC_HI) begin
      rd_val = asrc_r[sel_ch][63:32];
    end else begin
      rd_bad = 1'b1;
    end
  end

  // slave port: one-cycle answer to every request
  always @(posedge clk) begin
    if (!rst_n) begin
      s_ready <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_err   <= 1'b0;
    end else begin
      s_ready <= wr_go || rd_go;                                   // [R2]
      s_rdata <= rd_go ? rd_val : 32'h0000_0000;
      s_err   <= (wr_go || rd_go) && rd_bad && !wr_ro;
    end
  end

  // master port sequencing: one transaction in flight, shared round-robin
  // the order bit needs no extra logic: only one transaction is ever in flight
  always @(posedge clk) begin
    if (!rst_n) begin
      m_valid    <= 1'b0;
      m_src_addr <= 64'h0000_0000_0000_0000;
      m_dst_addr <= 64'h0000_0000_0000_0000;
      m_size     <= 7'h00;
      m_channel  <= 2'h0;
      rr_r       <= 2'h0;
      owner_r    <= 2'h0;
      inflight_r <= 1'b0;
      step_r     <= 64'h0000_0000_0000_0000;
    end else if (!inflight_r && pick_ok) begin
      m_valid    <= 1'b1;                                          // [R2]
      m_src_addr <= asrc_r[pick];
      m_dst_addr <= adst_r[pick];
      step_r     <= pick_step;
      m_size     <= (pick_step > 64'h0000_0000_0000_0040) ? 7'h40 : pick_step[6:0];
      m_channel  <= pick;
      owner_r    <= pick;
      rr_r       <= pick;
      inflight_r <= 1'b1;
    end else if (inflight_r) begin
      if (m_valid && m_ready) begin
        m_valid <= 1'b0;
      end
      if (m_done || m_bus_err) begin
        inflight_r <= 1'b0;
      end
    end
  end

  // per-channel register and transfer state
  generate
    for (g = 0; g < `DMA_CHANNELS; g = g + 1) begin : g_ch
      wire hit_w   = wr_go && (sel_ch == g);
      wire ctl_w   = hit_w && (sel_off == `DMA_OFF_CTRL);
      wire mine    = inflight_r && (owner_r == g);
      wire ok_end  = mine && m_done && !m_bus_err;
      wire bad_end = mine && m_bus_err;
      // bytes still to move once the transaction in flight completes
      wire [63:0] left = alen_r[g] - step_r;
      wire fin     = ok_end && (left == 64'h0000_0000_0000_0000);
      wire rpt     = ptype_r[g][`DMA_TYPE_REPEAT];
      wire claim   = ctl_w && s_wdata[`DMA_CTRL_RESERVE] && !ctrl_r[g][`DMA_CTRL_RESERVE];
      wire go      = ctl_w && s_wdata[`DMA_CTRL_START] && !ctrl_r[g][`DMA_CTRL_START];
      always @(posedge clk) begin
        if (!rst_n) begin
          ctrl_r[g]  <= `DMA_CTRL_RESET;                           // [R12]
          ptype_r[g] <= 32'h0000_0000;
          plen_r[g]  <= 64'h0000_0000_0000_0000;
          pdst_r[g]  <= 64'h0000_0000_0000_0000;
          psrc_r[g]  <= 64'h0000_0000_0000_0000;
          atype_r[g] <= 32'h0000_0000;
          alen_r[g]  <= 64'h0000_0000_0000_0000;
          adst_r[g]  <= 64'h0000_0000_0000_0000;
          asrc_r[g]  <= 64'h0000_0000_0000_0000;
          busy_r[g]  <= 1'b0;
          done_irq[g]  <= 1'b0;
          fault_irq[g] <= 1'b0;
        end else begin
          done_irq[g]  <= 1'b0;
          fault_irq[g] <= 1'b0;
          if (ctl_w) begin
            ctrl_r[g][`DMA_CTRL_DONE_IE] <= s_wdata[`DMA_CTRL_DONE_IE];
            ctrl_r[g][`DMA_CTRL_ERR_IE]  <= s_wdata[`DMA_CTRL_ERR_IE];
            if (s_wdata[`DMA_CTRL_RESERVE] || !ctrl_r[g][`DMA_CTRL_START]) begin
              ctrl_r[g][`DMA_CTRL_RESERVE] <= s_wdata[`DMA_CTRL_RESERVE]; // [R9]
            end
            // a software clear of done or error loses to a same-cycle set
            if (!s_wdata[`DMA_CTRL_DONE] && !fin) begin
              ctrl_r[g][`DMA_CTRL_DONE] <= 1'b0;
            end
            if (!s_wdata[`DMA_CTRL_ERR] && !bad_end) begin
              ctrl_r[g][`DMA_CTRL_ERR] <= 1'b0;
            end
          end
          // claiming wipes the pending set; otherwise one pending word is written
          if (claim) begin
            ctrl_r[g][`DMA_CTRL_DONE] <= 1'b0;                     // [R13]
            ctrl_r[g][`DMA_CTRL_ERR]  <= 1'b0;
            ptype_r[g] <= 32'h0000_0000;                           // [R8]
            plen_r[g]  <= 64'h0000_0000_0000_0000;
            pdst_r[g]  <= 64'h0000_0000_0000_0000;
            psrc_r[g]  <= 64'h0000_0000_0000_0000;
          end else if (hit_w) begin
            if (sel_off == `DMA_OFF_PTYPE) begin
              ptype_r[g] <= legal_type(s_wdata);                   // [R14]
            end else if (sel_off == `DMA_OFF_PLEN_LO) begin
              plen_r[g][31:0] <= s_wdata;                          // [R5]
            end else if (sel_off == `DMA_OFF_PLEN_HI) begin
              plen_r[g][63:32] <= s_wdata;
            end else if (sel_off == `DMA_OFF_PDST_LO) begin
              pdst_r[g][31:0] <= s_wdata;
            end else if (sel_off == `DMA_OFF_PDST_HI) begin
              pdst_r[g][63:32] <= s_wdata;
            end else if (sel_off == `DMA_OFF_PSRC_LO) begin
              psrc_r[g][31:0] <= s_wdata;
            end else if (sel_off == `DMA_OFF_PSRC_HI) begin
              psrc_r[g][63:32] <= s_wdata;
            end
          end
          // start copies the whole pending set into the active set
          if (go) begin
            ctrl_r[g][`DMA_CTRL_START] <= 1'b1;                    // [R10]
            atype_r[g] <= ptype_r[g];
            alen_r[g]  <= plen_r[g];
            adst_r[g]  <= pdst_r[g];
            asrc_r[g]  <= psrc_r[g];
          end
          // the issuing channel leaves arbitration until its answer returns
          if (!inflight_r && pick_ok && pick == g) begin
            busy_r[g] <= 1'b1;                                     // [R1]
          end
          // each good answer moves the active window on by one transaction
          if (ok_end) begin
            busy_r[g] <= 1'b0;
            alen_r[g] <= left;                                     // [R16]
            asrc_r[g] <= asrc_r[g] + step_r;
            adst_r[g] <= adst_r[g] + step_r;
          end
          if (fin) begin
            ctrl_r[g][`DMA_CTRL_DONE] <= 1'b1;                     // [R13]
            done_irq[g] <= ctrl_r[g][`DMA_CTRL_DONE_IE];           // [R11] [R3]
            if (rpt) begin
              atype_r[g] <= ptype_r[g];                            // [R15]
              alen_r[g]  <= plen_r[g];
              adst_r[g]  <= pdst_r[g];
              asrc_r[g]  <= psrc_r[g];
            end else begin
              ctrl_r[g][`DMA_CTRL_START] <= 1'b0;                  // [R16]
            end
          end
          // a bus error stops the channel and leaves the remaining length as is
          if (bad_end) begin
            busy_r[g] <= 1'b0;
            ctrl_r[g][`DMA_CTRL_ERR]   <= 1'b1;                    // [R13]
            ctrl_r[g][`DMA_CTRL_START] <= 1'b0;
            fault_irq[g] <= ctrl_r[g][`DMA_CTRL_ERR_IE];           // [R12] [R3]
          end
          // a start with nothing to move completes at once
          if (go && plen_r[g] == 64'h0000_0000_0000_0000 && !ctrl_r[g][`DMA_CTRL_START]) begin
            ctrl_r[g][`DMA_CTRL_DONE] <= 1'b1;
            ctrl_r[g][`DMA_CTRL_START] <= 1'b0;
            done_irq[g] <= ctrl_r[g][`DMA_CTRL_DONE_IE];
          end
        end
      end
    end
  endgenerate

endmodule

// ### sim/dma_engine_properties.sv
// port-level assertions for the four-channel copy engine
`timescale 1ns/1ps
module dma_engine_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        s_valid,
  input wire logic        s_ready,
  input wire logic [31:0] s_rdata,
  input wire logic        s_err,
  input wire logic        m_valid,
  input wire logic        m_ready,
  input wire logic        m_done,
  input wire logic        m_bus_err,
  input wire logic [63:0] m_src_addr,
  input wire logic [63:0] m_dst_addr,
  input wire logic [6:0]  m_size,
  input wire logic [1:0]  m_channel,
  input wire logic [3:0]  done_irq,
  input wire logic [3:0]  fault_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_req_answered: assert property (s_valid && !s_ready |=> s_ready)
    else $error("register request not answered next cycle");
  a_ready_pulse: assert property (s_ready |=> !s_ready)
    else $error("register answer longer than one cycle");
  a_rdata_idle: assert property (!s_ready |-> s_rdata == 32'h0000_0000)
    else $error("read data not zero outside an answer");
  a_err_with_ready: assert property (s_err |-> s_ready)
    else $error("slave error without answer");
  a_master_hold: assert property (m_valid && !m_ready |=> m_valid && $stable(m_src_addr)
    && $stable(m_dst_addr) && $stable(m_size) && $stable(m_channel))
    else $error("master request changed before accept");
  a_size_bound: assert property (m_valid |-> m_size >= 7'd1 && m_size <= 7'd64)
    else $error("transaction size out of range");
  a_accept_drop: assert property (m_valid && m_ready |=> !m_valid)
    else $error("master request held after accept");
  a_one_in_flight: assert property (m_done |-> !m_valid)
    else $error("new transaction issued before previous ended");
  a_done_irq_pulse: assert property (done_irq != 4'h0 |=> (done_irq & $past(done_irq)) == 4'h0)
    else $error("completion interrupt longer than one cycle");
  a_fault_irq_cause: assert property (fault_irq != 4'h0 |-> $past(m_bus_err)
    || $past(m_bus_err, 2) || $past(m_bus_err, 3)) else $error("error interrupt without bus error");
  c_slave_err: cover property (s_err);
  c_done_irq: cover property (done_irq != 4'h0);
  c_fault_irq: cover property (fault_irq != 4'h0);
  c_master_accept: cover property (m_valid && m_ready);
endmodule

bind dma_engine dma_engine_checker u_chk (.clk, .rst_n, .s_valid, .s_ready, .s_rdata, .s_err,
  .m_valid, .m_ready, .m_done, .m_bus_err, .m_src_addr, .m_dst_addr, .m_size, .m_channel,
  .done_irq, .fault_irq);

// ### sim/mem_target.sv
// memory-side target model answering the engine's master port
`timescale 1ns/1ps
module mem_target (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       m_valid,
  input  wire [3:0] delay,
  input  wire       fail,
  output reg        m_ready,
  output reg        m_done,
  output reg        m_bus_err
);
  reg [3:0] wait_r;
  reg       pend_r;
  // accepts after delay cycles, ends the transaction on the next cycle
  always @(posedge clk) begin
    m_ready <= 1'b0;
    m_done <= 1'b0;
    m_bus_err <= 1'b0;
    if (!rst_n) begin
      wait_r <= 4'h0;
      pend_r <= 1'b0;
    end else if (pend_r) begin
      pend_r <= 1'b0;
      m_done <= !fail;
      m_bus_err <= fail;
    end else if (m_valid && !m_ready) begin
      if (wait_r >= delay) begin
        m_ready <= 1'b1;
        pend_r <= 1'b1;
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

// ### sim/tb.sv
// self-checking bench for the four-channel copy engine
`timescale 1ns/1ps
`include "dma_defs.vh"
module tb;
  reg         clk, rst_n, s_valid, s_write, fail, er_v;
  reg  [13:0] s_addr;
  reg  [31:0] s_wdata, rd_v;
  reg  [3:0]  delay;
  wire        s_ready, s_err, m_valid, m_ready, m_done, m_bus_err;
  wire [31:0] s_rdata;
  wire [63:0] m_src_addr, m_dst_addr;
  wire [6:0]  m_size;
  wire [1:0]  m_channel;
  wire [3:0]  done_irq, fault_irq;
  integer     error_cnt, cmp_count, cyc, k, n;
  integer     done_n [0:3];
  integer     fault_n [0:3];

  dma_engine dut (.clk, .rst_n, .s_valid, .s_write, .s_addr, .s_wdata, .s_ready, .s_rdata,
    .s_err, .m_valid, .m_src_addr, .m_dst_addr, .m_size, .m_channel, .m_ready, .m_done,
    .m_bus_err, .done_irq, .fault_irq);
  mem_target u_mem (.clk, .rst_n, .m_valid, .delay, .fail, .m_ready, .m_done, .m_bus_err);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    for (k = 0; k < 4; k = k + 1) begin
      done_n[k] = done_n[k] + done_irq[k];
      fault_n[k] = fault_n[k] + fault_irq[k];
    end
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end

  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task acc(input w, input [1:0] c, input [11:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge clk);
      s_valid <= 1'b1;
      s_write <= w;
      s_addr <= {c, a};
      s_wdata <= d;
      t = 0;
      do begin @(negedge clk); t = t + 1; end while (s_ready !== 1'b1 && t < 20);
      if (t >= 20) error_cnt = error_cnt + 1;
      rd_v = s_rdata;
      er_v = s_err;
      @(posedge clk);
      s_valid <= 1'b0;
    end
  endtask
  task rchk(input [1:0] c, input [11:0] a, input [31:0] exp);
    begin
      acc(1'b0, c, a, 32'h0000_0000);
      chk(rd_v, exp);
    end
  endtask
  task prog(input [1:0] c, input [31:0] ty, input [31:0] len, input [31:0] dst,
            input [31:0] src);
    begin
      acc(1'b1, c, `DMA_OFF_CTRL, 32'h0000_0001);
      acc(1'b1, c, `DMA_OFF_PTYPE, ty);
      acc(1'b1, c, `DMA_OFF_PLEN_LO, len);
      acc(1'b1, c, `DMA_OFF_PDST_LO, dst);
      acc(1'b1, c, `DMA_OFF_PSRC_LO, src);
    end
  endtask
  task wait_stop(input [1:0] c);
    begin
      n = 0;
      rd_v = 32'h0000_0002;
      while (rd_v[1] !== 1'b0 && n < 200) begin
        acc(1'b0, c, `DMA_OFF_CTRL, 32'h0000_0000);
        n = n + 1;
      end
      if (rd_v[1] !== 1'b0) error_cnt = error_cnt + 1;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    s_valid = 1'b0;
    s_write = 1'b0;
    s_addr = 14'h0000;
    s_wdata = 32'h0000_0000;
    delay = 4'h3;
    fail = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    for (k = 0; k < 4; k = k + 1) begin
      done_n[k] = 0;
      fault_n[k] = 0;
    end
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rchk(0, `DMA_OFF_CTRL, `DMA_CTRL_RESET);
    acc(1'b0, 2, 12'h020, 32'h0000_0000);
    chk(er_v, 1);
    acc(1'b1, 1, `DMA_OFF_CTRL, 32'h0000_0001);
    acc(1'b1, 1, `DMA_OFF_PLEN_HI, 32'h0000_0005);
    rchk(1, `DMA_OFF_PLEN_HI, 32'h0000_0005);
    acc(1'b1, 1, `DMA_OFF_CTRL, 32'h0000_0000);
    acc(1'b1, 1, `DMA_OFF_CTRL, 32'h0000_0001);
    rchk(1, `DMA_OFF_PLEN_HI, 32'h0000_0000);
    acc(1'b1, 1, `DMA_OFF_PTYPE, 32'h7700_000c);
    rchk(1, `DMA_OFF_PTYPE, 32'h6600_000c);
    acc(1'b1, 1, `DMA_OFF_ALEN_LO, 32'h0000_0005);
    chk(er_v, 0);
    rchk(1, `DMA_OFF_ALEN_LO, 32'h0000_0000);
    // two channels run at once, only the first with completion interrupt
    prog(1, 32'h4400_0000, 32'h0000_0064, 32'h0000_2000, 32'h0000_1000);
    prog(2, 32'h3300_0000, 32'h0000_0028, 32'h0000_4000, 32'h0000_3000);
    acc(1'b1, 1, `DMA_OFF_CTRL, 32'h0000_4003);
    acc(1'b1, 2, `DMA_OFF_CTRL, 32'h0000_0003);
    acc(1'b1, 1, `DMA_OFF_CTRL, 32'h0000_4002);
    acc(1'b0, 1, `DMA_OFF_CTRL, 32'h0000_0000);
    chk(rd_v[0], 1);
    wait_stop(1);
    wait_stop(2);
    rchk(1, `DMA_OFF_CTRL, 32'h4000_4001);
    rchk(1, `DMA_OFF_ATYPE, 32'h4400_0000);
    rchk(1, `DMA_OFF_ALEN_LO, 32'h0000_0000);
    rchk(1, `DMA_OFF_ADST_LO, 32'h0000_2064);
    rchk(1, `DMA_OFF_ASRC_LO, 32'h0000_1064);
    rchk(2, `DMA_OFF_ADST_LO, 32'h0000_4028);
    rchk(2, `DMA_OFF_CTRL, 32'h4000_0001);
    chk(done_n[1], 1);
    chk(done_n[2], 0);
    // bus error on a channel with error interrupt enabled
    fail <= 1'b1;
    prog(3, 32'h0000_0000, 32'h0000_0010, 32'h0000_5000, 32'h0000_6000);
    acc(1'b1, 3, `DMA_OFF_CTRL, 32'h0000_8003);
    wait_stop(3);
    rchk(3, `DMA_OFF_CTRL, 32'h8000_8001);
    chk(fault_n[3], 1);
    chk(m_dst_addr, 64'h0000_0000_0000_5000);
    chk(m_src_addr, 64'h0000_0000_0000_6000);
    chk({m_channel, m_size}, {2'h3, 7'h01});
    fail <= 1'b0;
    // repeating transfer keeps start set until repeat is cleared
    delay <= 4'h0;
    prog(0, 32'h0000_0004, 32'h0000_0002, 32'h0000_7000, 32'h0000_8000);
    acc(1'b1, 0, `DMA_OFF_CTRL, 32'h0000_4003);
    n = 0;
    while (done_n[0] < 2 && n < 500) begin
      @(posedge clk);
      n = n + 1;
    end
    if (done_n[0] < 2) error_cnt = error_cnt + 1;
    acc(1'b0, 0, `DMA_OFF_CTRL, 32'h0000_0000);
    chk(rd_v[1], 1);
    acc(1'b1, 0, `DMA_OFF_PTYPE, 32'h0000_0000);
    wait_stop(0);
    rchk(0, `DMA_OFF_ALEN_LO, 32'h0000_0000);
    final_report;
  end
endmodule
